//--- logic/scw_clock_wake.sv
`timescale 1ns/100ps
// Functional notes
// R1: Internal mode oversamples fast clock, low field
// R2: Master accepts oversample factors four to sixteen
// R3: Software keeps master factor six to sixteen
// R4: Late sampling control resets cleared
// R5: Slave ignores factor, times from sampled clock
// R6: Software keeps clock ratio per filter settings
// R7: External select only slave, submode zero
// R8: Select source chooses internal or external detection
// R9: Software keeps transfer clock source zero
// R10: Both sources zero: internal, Active/Sleep only
// R11: External select detection sets wakeup cause
// R12: Software masks wakeup in Active state
// R13: Active/Sleep: internal logic carries the transfer
// R14: Deep-Sleep masked: refuse with ones on output
// R15: No function in Hibernate or Stop
// R16: Median control filters input lines, three taps
// R17: Software disables block before switching clocking
// R18: Wakeup cause sticky, crossed safely
// R19: Wakeup request only when cause and mask
module scw_clock_wake (
    input  wire logic                clock,        // System fast clock, 10 MHz
    input  wire logic                resetn,       // Synchronous reset, active low
    input  wire scw_pkg::scw_cfg_t   cfg,          // Block configuration
    input  wire scw_pkg::scw_power_t power_state,  // System power state
    input  wire logic                wake_mask,    // Wakeup cause mask
    input  wire logic                wake_clear,   // Clear wakeup cause, one-cycle pulse
    input  wire logic                sclk_in,      // Serial clock pin in
    input  wire logic                ssel_n_in,    // Slave select pin in, active low
    input  wire logic                mosi_in,      // Master-out line in
    input  wire logic                miso_in,      // Slave-out line in, used as master
    output logic                     sclk_out,     // Serial clock out as master
    output logic                     sclk_oe,      // Serial clock drive enable
    output logic                     miso_out,     // Slave-out line driven
    output logic                     miso_oe,      // Slave-out drive enable
    output logic                     wake_cause,   // Sticky wakeup cause
    output logic                     wake_irq,     // Wakeup interrupt request
    output logic                     bit_strobe,   // One-cycle pulse per sampled bit
    output logic                     sample_bit,   // Last sampled input bit
    output logic                     cfg_error     // Unsupported clocking setting
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    scw_pkg::scw_lines_t meta_reg;
    scw_pkg::scw_lines_t sync_reg;
    scw_pkg::scw_lines_t tap1_reg;
    scw_pkg::scw_lines_t tap2_reg;
    scw_pkg::scw_lines_t line;
    scw_pkg::scw_lines_t raw;

    assign raw = '{sclk: sclk_in, ssel_n: ssel_n_in, mosi: mosi_in, miso: miso_in};

    // Two stages for every pin; the first is read only by the second
    always_ff @(posedge clock) begin
        if (!resetn) begin
            meta_reg <= '{sclk: 1'b0, ssel_n: 1'b1, mosi: 1'b0, miso: 1'b0};
            sync_reg <= '{sclk: 1'b0, ssel_n: 1'b1, mosi: 1'b0, miso: 1'b0};
        end else begin
            meta_reg <= raw;
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Median filter
    // ------------------------------------------------------------
    // Three-tap history; costs one cycle of latency, hence the higher ratios
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tap1_reg <= '{sclk: 1'b0, ssel_n: 1'b1, mosi: 1'b0, miso: 1'b0};
            tap2_reg <= '{sclk: 1'b0, ssel_n: 1'b1, mosi: 1'b0, miso: 1'b0};
        end else begin
            tap1_reg <= sync_reg;
            tap2_reg <= tap1_reg;
        end
    end

    // Majority of three taps when enabled, bypass otherwise
    always_comb begin
        if (cfg.median) begin
            line = (sync_reg & tap1_reg) | (sync_reg & tap2_reg) | (tap1_reg & tap2_reg); // R16
        end else begin
            line = sync_reg; // R16
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic powered;
    logic int_ok;
    logic ext_sel;
    logic refuse;
    logic is_slave;

    // Nothing runs in Hibernate or Stop
    assign powered  = cfg.enable && (power_state == scw_pkg::PWR_ACTIVE ||
                                     power_state == scw_pkg::PWR_SLEEP ||
                                     power_state == scw_pkg::PWR_DEEP_SLEEP); // R15
    // Internal logic only in Active and Sleep
    assign int_ok   = powered && power_state != scw_pkg::PWR_DEEP_SLEEP; // R10 R13
    assign is_slave = !cfg.master_mode;
    // External select only for a slave in submode zero
    assign ext_sel  = powered && cfg.select_clock_source && is_slave &&
                      cfg.submode == scw_pkg::SUBMODE_MOTO0; // R7 R8
    assign refuse   = ext_sel && power_state == scw_pkg::PWR_DEEP_SLEEP && wake_mask; // R14

    // Flag settings the hardware does not support
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cfg_error <= 1'b0;
        end else begin
            cfg_error <= cfg.enable && (cfg.transfer_clock_source ||
                         (cfg.select_clock_source && !(is_slave &&
                          cfg.submode == scw_pkg::SUBMODE_MOTO0)) ||
                         (cfg.master_mode &&
                          cfg.oversample_factor < scw_pkg::OVS_MIN_M1)); // R2 R7 R9
        end
    end

    // ------------------------------------------------------------
    // Edge detection on the sampled serial clock
    // ------------------------------------------------------------
    logic sclk_prev_reg;
    logic ssel_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sclk_prev_reg <= 1'b0;
            ssel_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= line.sclk;
            ssel_prev_reg <= line.ssel_n;
        end
    end

    assign sclk_rise = line.sclk && !sclk_prev_reg; // R5
    assign sclk_fall = !line.sclk && sclk_prev_reg;
    assign sel_fall  = !line.ssel_n && ssel_prev_reg;

    // ------------------------------------------------------------
    // Master bit timing by oversampling
    // ------------------------------------------------------------
    logic [3:0] ovs_cnt_reg;
    logic       half_reg;
    logic       ovs_tick;
    logic [3:0] ovs_eff;
    logic [3:0] ovs_half;

    // Clamp below the supported minimum factor
    assign ovs_eff  = (cfg.oversample_factor < scw_pkg::OVS_MIN_M1) ?
                      scw_pkg::OVS_MIN_M1 : cfg.oversample_factor; // R2
    assign ovs_half = ovs_eff >> 1;
    assign ovs_tick = (ovs_cnt_reg == scw_pkg::CNT_ZERO);

    // Counter reloads each half bit; low field sets the factor
    always_ff @(posedge clock) begin
        if (!resetn || !(int_ok && cfg.master_mode)) begin
            ovs_cnt_reg <= scw_pkg::OVS_RST;
            half_reg    <= 1'b0;
        end else if (ovs_tick) begin
            half_reg    <= !half_reg;
            ovs_cnt_reg <= half_reg ? (ovs_eff - ovs_half - 4'h1) : ovs_half; // R1
        end else begin
            ovs_cnt_reg <= ovs_cnt_reg - 4'h1; // R1
        end
    end

    // Serial clock driven only as master in an internal state
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sclk_out <= 1'b0;
            sclk_oe  <= 1'b0;
        end else begin
            sclk_out <= int_ok && cfg.master_mode && half_reg;
            sclk_oe  <= int_ok && cfg.master_mode;
        end
    end

    // ------------------------------------------------------------
    // Sampling point
    // ------------------------------------------------------------
    logic sample_now;

    // Late sampling as master waits for the next half bit, giving slack
    assign sample_now = cfg.master_mode ?
                        (int_ok && ovs_tick && (half_reg ^ cfg.late_sample)) : // R4
                        (int_ok && !line.ssel_n && sclk_rise); // R5 R13

    always_ff @(posedge clock) begin
        if (!resetn) begin
            bit_strobe <= 1'b0;
            sample_bit <= 1'b0;
        end else begin
            bit_strobe <= sample_now;
            if (sample_now) begin
                sample_bit <= cfg.master_mode ? line.miso : line.mosi;
            end
        end
    end

    // ------------------------------------------------------------
    // Wakeup cause and request
    // ------------------------------------------------------------
    // Set beats clear so a select in the clearing cycle is kept
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wake_cause <= 1'b0;
        end else if (ext_sel && sel_fall) begin
            wake_cause <= 1'b1; // R11 R18
        end else if (wake_clear) begin
            wake_cause <= 1'b0; // R18
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= ((ext_sel && sel_fall) || (wake_cause && !wake_clear)) && wake_mask; // R19
        end
    end

    // ------------------------------------------------------------
    // Refusal of the interrupted transfer
    // ------------------------------------------------------------
    logic refusing_reg;

    // Hold the refusal for the whole selected period
    always_ff @(posedge clock) begin
        if (!resetn || line.ssel_n || !ext_sel) begin
            refusing_reg <= 1'b0;
        end else if (refuse && sel_fall) begin
            refusing_reg <= 1'b1; // R14
        end
    end

    // Slave output: ones while refusing, idle high otherwise
    always_ff @(posedge clock) begin
        if (!resetn) begin
            miso_out <= scw_pkg::ONES_BIT;
            miso_oe  <= 1'b0;
        end else begin
            miso_out <= scw_pkg::ONES_BIT; // R14
            miso_oe  <= is_slave && !line.ssel_n && (refusing_reg || int_ok) && powered;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_irq_gate: assert property (@(posedge clock) disable iff (!resetn) // R19
        wake_irq |-> $past(wake_mask))
        else $error("wake request without mask");
    a_cause_sticky: assert property (@(posedge clock) disable iff (!resetn) // R18
        wake_cause && !wake_clear |=> wake_cause)
        else $error("wake cause dropped");
    a_cause_set: assert property (@(posedge clock) disable iff (!resetn) // R11
        ext_sel && sel_fall |=> wake_cause)
        else $error("select not caught");
    // Refusal only owed while still selected with external select in force
    a_refuse_ones: assert property (@(posedge clock) disable iff (!resetn) // R14
        refusing_reg && ext_sel && !line.ssel_n |=> miso_out && miso_oe)
        else $error("refusal not driving ones");
    a_hib_quiet: assert property (@(posedge clock) disable iff (!resetn) // R15
        (power_state == scw_pkg::PWR_HIBERNATE) [*2] |-> !sclk_oe && !bit_strobe)
        else $error("activity in hibernate");
    a_deep_no_int: assert property (@(posedge clock) disable iff (!resetn) // R10
        power_state == scw_pkg::PWR_DEEP_SLEEP |=> !bit_strobe)
        else $error("internal sampling in deep sleep");
    a_master_clk: assert property (@(posedge clock) disable iff (!resetn) // R1
        !(int_ok && cfg.master_mode) |=> !sclk_oe)
        else $error("clock driven outside master");
    a_ext_slave: assert property (@(posedge clock) disable iff (!resetn) // R7
        cfg.master_mode && !wake_cause |=> !wake_cause)
        else $error("external select as master");
    a_late_point: assert property (@(posedge clock) disable iff (!resetn) // R4
        bit_strobe && cfg.master_mode && $past(cfg.master_mode) |->
        sclk_out != $past(cfg.late_sample))
        else $error("master sample point off");
    c_wake: cover property (@(posedge clock) disable iff (!resetn) wake_irq);
    c_refuse: cover property (@(posedge clock) disable iff (!resetn) refusing_reg);
    c_master_bit: cover property (@(posedge clock) disable iff (!resetn)
        bit_strobe && cfg.master_mode);
    c_slave_bit: cover property (@(posedge clock) disable iff (!resetn)
        bit_strobe && !cfg.master_mode);

endmodule

//--- logic/scw_pkg.sv
package scw_pkg;

    // ------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------
    localparam int          OVS_W        = 4;
    localparam logic [3:0]  OVS_MIN_M1   = 4'h3;  // Factor 4, field holds factor minus one
    localparam logic [3:0]  OVS_MAX_M1   = 4'hF;  // Factor 16
    localparam logic [3:0]  OVS_RST      = 4'hF;
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [2:0]  BIT_ZERO     = 3'h0;
    localparam logic        ONES_BIT     = 1'b1;  // Refusal level on the serial output

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PWR_ACTIVE     = 3'h0,
        PWR_SLEEP      = 3'h1,
        PWR_DEEP_SLEEP = 3'h2,
        PWR_HIBERNATE  = 3'h3,
        PWR_STOP       = 3'h4
    } scw_power_t;

    // ------------------------------------------------------------
    // Configuration carried as one group
    // ------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic       master_mode;
        logic [1:0] submode;                // 0: clock phase/polarity mode 0 submode
        logic [3:0] oversample_factor;      // Factor minus one
        logic       late_sample;
        logic       median;
        logic       select_clock_source;
        logic       transfer_clock_source;
    } scw_cfg_t;

    localparam logic [1:0] SUBMODE_MOTO0 = 2'h0;

    // Synchronised link inputs
    typedef struct packed {
        logic sclk;
        logic ssel_n;
        logic mosi;
        logic miso;
    } scw_lines_t;

endpackage

//--- verif/scw_spi_partner.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Far side: external master in mode 0, and a slave answering
// ----------------------------------------------------------------
module scw_spi_partner (
    input  wire logic dut_sclk,  // Serial clock from the block as master
    output logic      sclk,      // Serial clock to the block
    output logic      ssel_n,    // Slave select, active low
    output logic      mosi,      // Master-out data
    output logic      miso       // Slave-out data to the block
);
    // A deselected data line keeps moving so a stale value never matches
    initial begin
        sclk   = 1'b0;
        ssel_n = 1'b1;
        mosi   = 1'b0;
        miso   = 1'b0;
        forever #100 if (ssel_n) mosi = ~mosi;
    end

    // Slave answer moves on the falling edge of the block's clock
    always @(negedge dut_sclk) miso <= ~miso;

    // One byte, most significant bit first; clock idles low between frames
    task automatic frame(input logic [7:0] b);
        #37 ssel_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            #400 sclk = 1'b1;
            #400 sclk = 1'b0;
        end
        #400 ssel_n = 1'b1;
    endtask
endmodule

//--- verif/test_spi_clocking_wake_control.sv
`timescale 1ns/100ps
module test_spi_clocking_wake_control;
    logic                clock;
    logic                resetn;
    scw_pkg::scw_cfg_t   cfg;
    scw_pkg::scw_cfg_t   nc;
    scw_pkg::scw_power_t power_state;
    logic                wake_mask, wake_clear, sclk_in, ssel_n_in, mosi_in, miso_in;
    logic                sclk_out, sclk_oe, miso_out, miso_oe, wake_cause, wake_irq;
    logic                bit_strobe, sample_bit, cfg_error, refused;
    logic [7:0]          got, b;
    int                  n_fail, check_count, n_bits, seed;

    scw_clock_wake scw_clock_wake_i (.clock(clock), .resetn(resetn), .cfg(cfg),
        .power_state(power_state), .wake_mask(wake_mask), .wake_clear(wake_clear),
        .sclk_in(sclk_in), .ssel_n_in(ssel_n_in), .mosi_in(mosi_in), .miso_in(miso_in),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .miso_out(miso_out), .miso_oe(miso_oe),
        .wake_cause(wake_cause), .wake_irq(wake_irq), .bit_strobe(bit_strobe),
        .sample_bit(sample_bit), .cfg_error(cfg_error));
    scw_spi_partner scw_spi_partner_i (.dut_sclk(sclk_out), .sclk(sclk_in),
        .ssel_n(ssel_n_in), .mosi(mosi_in), .miso(miso_in));

    // Clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Gather sampled bits; note a refusal level seen while selected
    always @(posedge clock) begin
        if (bit_strobe === 1'b1) begin
            got    <= {got[6:0], sample_bit};
            n_bits <= n_bits + 1;
        end
        if (ssel_n_in === 1'b0 && miso_oe === 1'b1 && miso_out === 1'b1) refused <= 1'b1;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Disable before every change of clocking, then enable with the new setting
    task automatic reconfig(input scw_pkg::scw_cfg_t c);
        cfg = '0;
        step(1);
        cfg = c;
        step(2);
    endtask

    task automatic slave_frame(input logic [7:0] v);
        n_bits  = 0;
        refused = 1'b0;
        scw_spi_partner_i.frame(v);
        step(8);
    endtask

    // Count clocks between two rises of the master clock; a miss reads as 0
    task automatic master_period(input logic [3:0] f);
        int   r[$];
        logic last;
        nc.oversample_factor = f;
        reconfig(nc);
        last = sclk_out;
        for (int k = 0; k < 200 && r.size() < 2; k++) begin
            step(1);
            if (sclk_out === 1'b1 && last === 1'b0) r.push_back(k);
            last = sclk_out;
        end
        if (r.size() < 2) r = '{0, 0};
        check("bit period", 8'(r[1] - r[0]), 8'(f) + 8'h01);
        check("master drive", {7'h0, sclk_oe}, 8'h01);
        check("factor flag", {7'h0, cfg_error}, 8'h00);
    endtask

    task automatic clear_cause();
        wake_clear = 1'b1;
        step(1);
        wake_clear = 1'b0;
        step(2);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        seed        = 32'h7D10A24C;
        cfg         = '0;
        nc          = '0;
        power_state = scw_pkg::PWR_ACTIVE;
        wake_mask   = 1'b0;
        wake_clear  = 1'b0;
        resetn      = 1'b0;
        {n_fail, check_count, n_bits, refused, got} = '0;
        step(4);
        resetn = 1'b1;
        check("idle", {sclk_oe, miso_oe, wake_cause, wake_irq, cfg_error, miso_out, 2'h0},
              8'h04);
        // Slave: factor field and late sampling are noise; an 8-clock link
        nc.enable = 1'b1;
        for (int m = 0; m < 4; m++) begin
            nc.median            = m[0];
            nc.late_sample       = 1'b1;
            nc.oversample_factor = 4'($random(seed));
            reconfig(nc);
            b = 8'($random(seed));
            slave_frame(b);
            check("slave bits", got, b);
            check("bit count", 8'(n_bits), 8'h08);
        end
        // Master: lowest accepted factor, a random legal one, one below range
        nc             = '0;
        nc.enable      = 1'b1;
        nc.master_mode = 1'b1;
        master_period(4'h3);
        nc.late_sample = 1'b1;
        master_period(4'h5 + 4'(($random(seed) & 32'h7FFFFFFF) % 11));
        nc.oversample_factor = 4'h2;
        reconfig(nc);
        check("low factor flag", {7'h0, cfg_error}, 8'h01);
        // Deep-Sleep wake: cause, request, refusal, hold, mask, clear
        nc                     = '0;
        nc.enable              = 1'b1;
        nc.select_clock_source = 1'b1;
        nc.late_sample         = 1'b1;
        reconfig(nc);
        power_state = scw_pkg::PWR_DEEP_SLEEP;
        wake_mask   = 1'b1;
        slave_frame(8'hA5);
        check("wake cause", {7'h0, wake_cause}, 8'h01);
        check("wake request", {7'h0, wake_irq}, 8'h01);
        check("refusal ones", {7'h0, refused}, 8'h01);
        wake_mask = 1'b0;
        step(2);
        check("cause held", {7'h0, wake_cause}, 8'h01);
        check("request masked", {7'h0, wake_irq}, 8'h00);
        clear_cause();
        check("cause cleared", {7'h0, wake_cause}, 8'h00);
        // Sleep: internal logic still moves the data
        power_state = scw_pkg::PWR_SLEEP;
        wake_mask   = 1'b1;
        b           = 8'($random(seed));
        slave_frame(b);
        check("sleep bits", got, b);
        check("sleep cause", {7'h0, wake_cause}, 8'h01);
        clear_cause();
        // Hibernate, Stop, master, other submode, internal select: no wake
        for (int c = 0; c < 5; c++) begin
            nc.select_clock_source = (c != 4);
            nc.master_mode         = (c == 2);
            nc.submode             = (c == 3) ? 2'h1 : scw_pkg::SUBMODE_MOTO0;
            reconfig(nc);
            power_state = (c == 0) ? scw_pkg::PWR_HIBERNATE :
                          (c == 1) ? scw_pkg::PWR_STOP : scw_pkg::PWR_DEEP_SLEEP;
            slave_frame(8'h3C);
            check("no wake", {7'h0, wake_cause}, 8'h00);
        end
        print_verdict();
    end
endmodule
